// ---- src/msr_pkg.sv ----
package msr_pkg;
    // ==========================================================
    // widths and reset values
    localparam int         MSR_WIDTH      = 4;
    localparam logic [3:0] MSR_RESET_VAL  = 4'h0;
    localparam logic       MSR_SER_N_RST  = 1'h1;
    localparam int         MSR_SYNC_DEPTH = 2;

    // ==========================================================
    // operating states, one-hot
    typedef enum logic [2:0] {
        MSR_HOLD  = 3'b001,
        MSR_LOAD  = 3'b010,
        MSR_SHIFT = 3'b100
    } msr_mode_t;
endpackage

// ---- src/msr_sync.sv ----
`timescale 1ns/1ps
module msr_sync
    import msr_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // pin side and synchronised side
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // ==========================================================
    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // msr_sync

// ---- src/msr_shift_reg.sv ----
`timescale 1ns/1ps
// Behaviour
// (RULE1) four bits, serial or parallel entry
// (RULE2) three modes: shift, load, hold
// (RULE3) shift wins; load alone loads; else hold
// (RULE4) data changes only on enabled clock edge
// (RULE5) stages update on falling edge of clock
// (RULE6) direct clear and complemented serial output; clear is synchronised and reaches the stages three cycles after the pin
// (RULE7) driver may tie load high, shift selects
// (RULE8) shift moves low to high; clear zeroes
module msr_shift_reg
    import msr_pkg::*;
#(
    parameter int WIDTH = MSR_WIDTH
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // pins from the driving logic
    input  wire logic             shift_clk,
    input  wire logic             load_en,
    input  wire logic             shift_en,
    input  wire logic             ser_in,
    input  wire logic [WIDTH-1:0] par_in,
    input  wire logic             dir_clr,
    // register outputs
    output logic      [WIDTH-1:0] stage_q,
    output logic                  ser_out_n
);
    localparam int SW = WIDTH + 5;

    logic [SW-1:0]    pins_s;
    logic             clk_s;
    logic             clk_prev_q;
    logic             fall_edge;
    logic             load_s;
    logic             shift_s;
    logic             ser_s;
    logic             clr_s;
    logic [WIDTH-1:0] par_s;
    msr_mode_t        mode;
    logic [WIDTH-1:0] stage_d;
    logic [WIDTH-1:0] shift_next;

    // ==========================================================
    // pins come from another domain, so all are synchronised together
    msr_sync #(
        .WIDTH(SW)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst (sys_rst),
        .async_in({shift_clk, load_en, shift_en, ser_in, dir_clr, par_in}),
        .sync_out(pins_s)
    );

    assign {clk_s, load_s, shift_s, ser_s, clr_s, par_s} = pins_s;

    // ==========================================================
    // edge detect on the synchronised pin clock
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    assign fall_edge = clk_prev_q & ~clk_s; // [RULE5]

    // ==========================================================
    // mode decode; shift is tested first so it wins over load
    function automatic msr_mode_t decode_mode(input logic load, input logic shift);
        msr_mode_t m;
        if (shift) begin
            m = MSR_SHIFT; // [RULE3] [RULE7]
        end else if (load) begin
            m = MSR_LOAD; // [RULE3]
        end else begin
            m = MSR_HOLD; // [RULE2]
        end
        return m;
    endfunction

    always_comb begin
        mode = decode_mode(load_s, shift_s);
    end

    // ==========================================================
    // shift path: stage i takes stage i-1, stage 0 the serial pin
    // a loop keeps the chain right for any width parameter
    for (genvar i = 0; i < WIDTH; i++) begin : g_stage
        if (i == 0) begin : g_first
            assign shift_next[i] = ser_s; // [RULE8]
        end else begin : g_next
            assign shift_next[i] = stage_q[i-1]; // [RULE8]
        end
    end

    always_comb begin
        case (mode)
            MSR_SHIFT: stage_d = shift_next; // [RULE8] [RULE1]
            MSR_LOAD:  stage_d = par_s; // [RULE1]
            default:   stage_d = stage_q;
        endcase
    end

    // ==========================================================
    // storage; clear is a level so it acts on any cycle, edge or not.
    // limitation: clear reaches the stages three cycles after the pin, not at once.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_q <= MSR_RESET_VAL;
        end else if (clr_s) begin
            stage_q <= MSR_RESET_VAL; // [RULE6] [RULE8]
        end else if (fall_edge) begin
            stage_q <= stage_d; // [RULE4]
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_out_n <= MSR_SER_N_RST;
        end else if (clr_s) begin
            ser_out_n <= MSR_SER_N_RST; // [RULE6]
        end else if (fall_edge) begin
            ser_out_n <= ~stage_d[WIDTH-1]; // [RULE6]
        end
    end

    // ==========================================================
    // checks
    sequence fall_s;
        $past(clk_s) && !clk_s;
    endsequence

    hold_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
        (!clr_s && !shift_s && !load_s) |=> $stable(stage_q))
        else $error("hold mode changed stage contents");

    load_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
        (fall_edge && !clr_s && load_s && !shift_s) |=> stage_q == $past(par_s))
        else $error("parallel entry did not load inputs");

    shift_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
        (fall_edge && !clr_s && shift_s)
        |=> stage_q == {$past(stage_q[WIDTH-2:0]), $past(ser_s)})
        else $error("shift right gave wrong stage values");

    no_edge_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE4]
        (!fall_edge && !clr_s) |=> $stable(stage_q))
        else $error("stages changed without clock edge");

    fall_only_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
        (!clr_s && $past(clk_s) == clk_s) |=> $stable(stage_q))
        else $error("stages changed without falling edge");

    fall_seq_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
        fall_s |-> fall_edge)
        else $error("falling edge not detected");

    clear_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        clr_s |=> (stage_q == MSR_RESET_VAL) && ser_out_n)
        else $error("direct clear did not zero stages");

    ser_comp_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        ser_out_n == ~stage_q[WIDTH-1])
        else $error("complement output mismatch");

    width_ok_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
        (fall_edge && !clr_s && shift_s) |=> stage_q[0] == $past(ser_s))
        else $error("serial input missed first stage");

    // ==========================================================
    // pin-to-output checks: two synchroniser flops and the storage flop
    // put every update three edges after the pin; the driving logic must
    // hold controls and data steady over the sampled fall
    sequence pin_fall_s;
        shift_clk ##1 !shift_clk;
    endsequence

    sequence pin_rise_s;
        !shift_clk ##1 shift_clk;
    endsequence

    sequence clr_held_s;
        dir_clr [*3];
    endsequence

    pin_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
        (pin_fall_s ##0 (!dir_clr && load_en && !shift_en))
        |-> ##3 stage_q == $past(par_in, 3))
        else $error("pin load did not reach stages");

    ser_pin_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        (pin_fall_s ##0 (!dir_clr && load_en && !shift_en))
        |-> ##3 ser_out_n == !$past(par_in[WIDTH-1], 3))
        else $error("complement output wrong after pin load");

    pin_shift_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
        (pin_fall_s ##0 (!dir_clr && shift_en))
        |-> ##3 stage_q == {$past(stage_q[WIDTH-2:0]), $past(ser_in, 3)})
        else $error("pin shift moved wrong values");

    pin_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
        (pin_fall_s ##0 (!dir_clr && !load_en && !shift_en))
        |-> ##3 $stable(stage_q))
        else $error("hold mode let a pin edge through");

    rise_ignored_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE5]
        (pin_rise_s ##0 !dir_clr) |-> ##3 $stable(stage_q))
        else $error("rising pin edge changed stages");

    clear_wins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        (pin_fall_s ##0 dir_clr) |-> ##3 stage_q == MSR_RESET_VAL)
        else $error("edge overrode direct clear");

    // the pin clear is a level, so three edges of it must be enough
    pin_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE8]
        clr_held_s |=> (stage_q == MSR_RESET_VAL) && ser_out_n)
        else $error("direct clear pin not seen in three cycles");

    // reset values must show at the first edge after release
    reset_value_a: assert property (@(posedge core_clk) // [RULE6]
        $fell(sys_rst) |-> (stage_q == MSR_RESET_VAL) && ser_out_n)
        else $error("outputs not at reset values after reset");
endmodule // msr_shift_reg

// ---- tb/msr_drv.sv ----
`timescale 1ns/1ps
// ====
// driving logic: one shift clock pulse per transfer
module msr_drv (
    // clock
    input  wire logic       core_clk,
    // pins toward the register
    output logic            shift_clk,
    output logic            load_en,
    output logic            shift_en,
    output logic            ser_in,
    output logic [3:0]      par_in
);
    initial {shift_clk, load_en, shift_en, ser_in, par_in} = 8'h80;
    // controls settle 3 cycles before the fall and hold 1 after the rise
    task automatic xfer(input logic l, s, d, input logic [3:0] p);
        {load_en, shift_en, ser_in, par_in} = {l, s, d, p};
        repeat (3) @(posedge core_clk);
        #1 shift_clk = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 shift_clk = 1'b1;
        @(posedge core_clk);
        // data no longer held: show the inverse, not stale values
        #1 {ser_in, par_in} = ~{d, p};
    endtask
endmodule // msr_drv

// ---- tb/msr_shift_reg_tb.sv ----
`timescale 1ns/1ps
module msr_shift_reg_tb;
    import msr_pkg::*;
    logic       core_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       dir_clr  = 1'b0;
    logic       shift_clk, load_en, shift_en, ser_in, ser_out_n;
    logic [3:0] par_in, stage_q, m;
    logic [4:0] q[$];
    int         fails = 0, checks = 0, seed = 13825;
    always #5 core_clk = ~core_clk;
    msr_drv u_drv (.core_clk(core_clk), .shift_clk(shift_clk), .load_en(load_en),
        .shift_en(shift_en), .ser_in(ser_in), .par_in(par_in));
    msr_shift_reg u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .shift_clk(shift_clk),
        .load_en(load_en), .shift_en(shift_en), .ser_in(ser_in), .par_in(par_in),
        .dir_clr(dir_clr), .stage_q(stage_q), .ser_out_n(ser_out_n));
    // ====
    // compare and report
    task automatic cmp(input logic [4:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // oldest note is due once it has been queued; read mid-cycle, where outputs
    // have settled, never in the time step of the edge that launches them
    always @(negedge core_clk) begin
        if (q.size() > 0) cmp({ser_out_n, stage_q}, q.pop_front());
    end
    // one transfer with random data, expectation from the mode table
    task automatic op(input logic l, s);
        logic       d;
        logic [3:0] p;
        {p, d} = 5'($random(seed));
        u_drv.xfer(l, s, d, p);
        m = s ? {m[2:0], d} : (l ? p : m);
        repeat (2) @(posedge core_clk);
        #1 q.push_back({~m[3], m});
    endtask
    // ====
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        m = 4'h0;
        q.push_back(5'h10);
        repeat (3) @(posedge core_clk);
        #1;
        for (int i = 0; i < 16; i++) op(i[0], i[1]);
        $display("test modes done");
        for (int i = 0; i < 6; i++) op(1'b1, i[0]);
        $display("test load tied high done");
        @(posedge core_clk);
        #1 dir_clr = 1'b1;
        m = 4'h0;
        // the edge below must not load while clear is held
        u_drv.xfer(1'b1, 1'b0, 1'b1, 4'hf);
        q.push_back(5'h10);
        @(posedge core_clk);
        #1 dir_clr = 1'b0;
        op(1'b1, 1'b0);
        op(1'b0, 1'b1);
        $display("test clear done");
        repeat (3) @(posedge core_clk);
        results();
    end
    initial begin
        #200000;
        fails++;
        results();
    end
endmodule // msr_shift_reg_tb
